// >>> hw/mezz_pkg.sv
package mezz_pkg;
  localparam int NMOD = 6;
  // Register offsets
  localparam logic [7:0] CTL_BASE = 8'h08;
  localparam logic [7:0] CTL_STRIDE = 8'h18;
  localparam logic [7:0] STAT_OFS = 8'hb0;
  localparam logic [7:0] MFR_OFS = 8'hb4;
  localparam logic [7:0] DTYPE_OFS = 8'hb8;
  localparam logic [15:0] CTL_RESET = 16'h0000;
  // Control word fields
  localparam int LVL_LSB = 0;
  localparam int FAR_BIT = 3;
  localparam int IGN_BIT = 4;
  localparam int VSS_BIT = 5;
  localparam int INH_BIT = 6;
  localparam int VEC_LSB = 8;
  // Identification words and codes
  localparam logic [15:0] SYNC_BASE = 16'h5346;
  localparam logic [15:0] SYNC_EXT = 16'hacba;
  localparam logic [5:0] W_SYNC = 6'h00;
  localparam logic [5:0] W_SYNCX = 6'h10;
  localparam logic [5:0] W_MFR = 6'h11;
  localparam logic [5:0] W_DTYPE = 6'h12;
  localparam int MODEL_LSB = 0;
  localparam int REQMEM_LSB = 12;
  localparam logic [4:0] REQMEM_EXP = 5'h17;
  // Arbitrary defaults, reported until a module supplies its own
  localparam logic [15:0] DEF_MFR = 16'h0f00;
  localparam logic [15:0] DEF_DTYPE = 16'hf000;
  // Timing
  localparam int CLK_PS = 4000;
  localparam int ID_BIT_NS = 1000;
  localparam int ID_BIT_CYC = (ID_BIT_NS * 1000 + CLK_PS - 1) / CLK_PS;
endpackage : mezz_pkg

// >>> hw/int_channel.sv
`timescale 1ns/100ps
module int_channel
  import mezz_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Module and settings
  input wire logic modIrq,
  input wire logic [2:0] level,
  input wire logic forceRelease,
  input wire logic granted,
  // Status
  output logic reqOut,
  output logic holding
);
  typedef enum logic [1:0] {C_IDLE = 2'b00, C_REQ = 2'b01, C_HOLD = 2'b10} chan_t;
  typedef struct packed {
    chan_t st;
  } state_t;
  state_t s_q, s_d;

  always_comb
  begin
    s_d = s_q;
    unique case (s_q.st)
      C_IDLE: if (modIrq && level != 3'h0) s_d.st = C_REQ;
      C_REQ:
      begin
        if (level == 3'h0 || !modIrq) s_d.st = C_IDLE;
        else if (granted) s_d.st = forceRelease ? C_HOLD : C_IDLE;
      end
      // Served but module not yet cleared
      C_HOLD: if (!modIrq) s_d.st = C_IDLE;
      default: s_d.st = C_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge rst)
    if (rst) s_q <= '{st: C_IDLE};
    else s_q <= s_d;

  assign reqOut = s_q.st == C_REQ;
  assign holding = s_q.st == C_HOLD;

  a_hold_till_clear: assert property (@(posedge clk) disable iff (rst)
    holding && modIrq |=> holding) else $error("hold left early");
  a_force_release: assert property (@(posedge clk) disable iff (rst)
    reqOut && granted && forceRelease && modIrq && level != 3'h0 |=> holding && !reqOut)
    else $error("no release on ack");
endmodule : int_channel

// >>> hw/ident_scan.sv
`timescale 1ns/100ps
module ident_scan
  import mezz_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Serial ident line
  input wire logic idData,
  input wire logic [5:0] modEnable,
  output logic [5:0] idSel,
  output logic idClk,
  output logic idDout,
  // Results
  output logic extFound,
  output logic [15:0] mfrId,
  output logic [15:0] devType,
  output logic testFail,
  output logic done
);
  typedef enum logic [1:0] {I_NEXT = 2'b00, I_ADDR = 2'b01, I_DATA = 2'b10, I_DONE = 2'b11} scan_t;
  typedef struct packed {
    scan_t st;
    logic [2:0] mod;
    logic [1:0] wrd;
    logic [4:0] bitN;
    logic [8:0] cnt;
    logic [15:0] sh;
    logic [15:0] w0;
    logic [15:0] w16;
    logic [15:0] w17;
    logic [5:0] sel;
    logic sck;
    logic dout;
    logic ext;
    logic [15:0] mfr;
    logic [15:0] dtype;
    logic fail;
    logic fin;
    logic [1:0] settle;
  } state_t;
  state_t s_q, s_d;
  logic [5:0] wAddr;
  logic bitEnd;

  always_comb
  begin
    unique case (s_q.wrd)
      2'b00: wAddr = W_SYNC;
      2'b01: wAddr = W_SYNCX;
      2'b10: wAddr = W_MFR;
      2'b11: wAddr = W_DTYPE;
    endcase
    bitEnd = s_q.cnt == 9'(ID_BIT_CYC - 1);
    s_d = s_q;
    s_d.cnt = bitEnd ? 9'h000 : 9'(s_q.cnt + 9'h001);
    s_d.sck = s_q.cnt >= 9'(ID_BIT_CYC / 2);
    unique case (s_q.st)
      I_NEXT:
      begin
        s_d.cnt = 9'h000;
        s_d.sck = 1'b0;
        s_d.bitN = 5'h00;
        // Slot enables need two cycles through their synchroniser
        if (s_q.settle != 2'h3) s_d.settle = 2'(s_q.settle + 2'h1);
        else if (s_q.mod == 3'(NMOD)) s_d.st = I_DONE;
        else if (!modEnable[s_q.mod]) s_d.mod = 3'(s_q.mod + 3'h1);
        else
        begin
          // One bit per access: address first, MSB first
          s_d.sel = 6'h01 << s_q.mod;
          s_d.st = I_ADDR;
          s_d.dout = wAddr[5];
        end
      end
      I_ADDR: if (bitEnd)
      begin
        s_d.bitN = 5'(s_q.bitN + 5'h01);
        if (s_q.bitN == 5'h05)
        begin
          s_d.bitN = 5'h00;
          s_d.dout = 1'b0;
          s_d.st = I_DATA;
        end
        else s_d.dout = wAddr[3'(4 - s_q.bitN)];
      end
      I_DATA: if (bitEnd)
      begin
        s_d.sh = {s_q.sh[14:0], idData};
        s_d.bitN = 5'(s_q.bitN + 5'h01);
        if (s_q.bitN == 5'h0f)
        begin
          s_d.st = I_ADDR;
          s_d.bitN = 5'h00;
          s_d.wrd = 2'(s_q.wrd + 2'h1);
          s_d.dout = 1'b0;
          unique case (s_q.wrd)
            2'b00: s_d.w0 = {s_q.sh[14:0], idData};
            2'b01: s_d.w16 = {s_q.sh[14:0], idData};
            2'b10: s_d.w17 = {s_q.sh[14:0], idData};
            2'b11:
            begin
              // Lowest module with extended words wins
              if (!s_q.ext && s_q.w0 == SYNC_BASE && s_q.w16 == SYNC_EXT)
              begin
                s_d.ext = 1'b1;
                s_d.mfr = s_q.w17;
                s_d.dtype = {s_q.sh[14:0], idData};
              end
              // Stuck-low line on an enabled slot fails self-test
              if (s_q.w0 == 16'h0000) s_d.fail = 1'b1;
              s_d.st = I_NEXT;
              s_d.sel = 6'h00;
              s_d.mod = 3'(s_q.mod + 3'h1);
            end
          endcase
        end
      end
      I_DONE:
      begin
        s_d.fin = 1'b1;
        s_d.sck = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst)
    if (rst) s_q <= '{st: I_NEXT, mfr: DEF_MFR, dtype: DEF_DTYPE, default: '0};
    else s_q <= s_d;

  assign idSel = s_q.sel;
  assign idClk = s_q.sck;
  assign idDout = s_q.dout;
  assign extFound = s_q.ext;
  assign mfrId = s_q.mfr;
  assign devType = s_q.dtype;
  assign testFail = s_q.fail;
  assign done = s_q.fin;

  a_ext_adopt: assert property (@(posedge clk) disable iff (rst)
    $rose(s_q.ext) |-> s_q.mfr == $past(s_q.w17) && $past(s_q.w16) == SYNC_EXT) else $error("bad adopt");
endmodule : ident_scan

// >>> hw/mezzanine_interrupt_ident_bridge.sv
// What this block does
// - Each module's backplane level comes from its control register level field.
// - Level field zero keeps that module's interrupt off the backplane.
// - Vector select zero puts the programmed vector in the status upper byte.
// - Status lower byte is the module's logical address.
// - Vector-supplying modules give the status upper byte during acknowledge.
// - Forced acknowledge release drops the backplane request on acknowledge.
// - With forced release, the module interrupt stays pending until serviced.
// - Ignore bit set: the module's acknowledge response is disregarded.
// - With forced release, no new backplane interrupt from a module until it clears.
// - Ident data is a serial EEPROM of 16-bit words read one bit per access.
// - At power-up each enabled module is checked for extended identification.
// - Extended ident replaces reported manufacturer, memory and model.
// - Word 0 sync 5346, word 16 ACBA, 17 manufacturer, 18 device type.
// - Device type: model in bits 0-11, memory code in bits 12-15.
// - Memory code m means two to the power 23 minus m bytes.
// - Power-up self-test failure asserts system failure and lights the lamp.
// - Any module's failure-inhibit bit suppresses system failure slot-wide.
//
// Our own choice: the APB interface to the registers.
`timescale 1ns/100ps
module mezzanine_interrupt_ident_bridge
  import mezz_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Backplane interrupt and acknowledge
  output logic [6:0] irqOut,
  input wire logic iackActive,
  input wire logic [2:0] iackLevel,
  input wire logic ackIn,
  output logic ackOut,
  output logic [15:0] statusId,
  output logic statusIdValid,
  // Modules
  input wire logic [5:0] modIrq,
  input wire logic [5:0][7:0] modVector,
  input wire logic [5:0] modAckDone,
  output logic [5:0] modAck,
  input wire logic [5:0] modEnable,
  // Address straps
  input wire logic [7:0] laBase,
  input wire logic modulo8,
  // Ident serial line
  input wire logic idDataIn,
  output logic [5:0] idSel,
  output logic idClk,
  output logic idDout,
  // Failure
  output logic sysfail,
  output logic failLamp
);
  // ************************************************
  // State
  // ************************************************
  typedef enum logic [1:0] {A_IDLE = 2'b00, A_WAIT = 2'b01, A_HOLD = 2'b10} ack_t;
  typedef struct packed {
    logic [5:0][15:0] ctl;
    logic [5:0] irqA, irqB, doneA, doneB, enA, enB;
    logic [5:0][7:0] vecA, vecB;
    logic iackA, iackB, ackInA, ackInB, dinA, dinB, m8A, m8B;
    logic [2:0] lvlA, lvlB;
    logic [7:0] laA, laB;
    ack_t ast;
    logic [2:0] sel;
    logic [5:0] grant;
    logic [5:0] mAck;
    logic aOut;
    logic [15:0] sid;
    logic sidV;
    logic [6:0] irq;
    logic sf, lamp;
    logic [31:0] rd;
    logic rdy, err;
  } state_t;
  state_t s_q, s_d;
  logic [5:0] chReq, chHold;
  logic extFound, testFail, scanDone, anyInh, hit, wrEn;
  logic [15:0] mfrId, devType;
  logic [2:0] hitIdx;

  function automatic logic [7:0] laOf(input logic [7:0] b, input logic m8, input int i);
    return m8 ? 8'(b + 8'(i * 8)) : 8'(b + 8'(i));
  endfunction : laOf

  // ************************************************
  // Per-module channels
  // ************************************************
  genvar g;
  generate
    for (g = 0; g < NMOD; g++)
    begin : gChan
      int_channel uChan (
        .clk(clk),
        .rst(rst),
        .modIrq(s_q.irqB[g]),
        .level(s_q.ctl[g][LVL_LSB +: 3]),
        .forceRelease(s_q.ctl[g][FAR_BIT]),
        .granted(s_q.grant[g]),
        .reqOut(chReq[g]),
        .holding(chHold[g])
      );
    end
  endgenerate

  ident_scan uScan (
    .clk(clk),
    .rst(rst),
    .idData(s_q.dinB),
    .modEnable(s_q.enB),
    .idSel(idSel),
    .idClk(idClk),
    .idDout(idDout),
    .extFound(extFound),
    .mfrId(mfrId),
    .devType(devType),
    .testFail(testFail),
    .done(scanDone)
  );

  // ************************************************
  // Next state
  // ************************************************
  always_comb
  begin
    s_d = s_q;
    // Pin synchronisers, first stage feeds only the second
    s_d.irqA = modIrq;
    s_d.irqB = s_q.irqA;
    s_d.doneA = modAckDone;
    s_d.doneB = s_q.doneA;
    s_d.enA = modEnable;
    s_d.enB = s_q.enA;
    s_d.vecA = modVector;
    s_d.vecB = s_q.vecA;
    s_d.iackA = iackActive;
    s_d.iackB = s_q.iackA;
    s_d.ackInA = ackIn;
    s_d.ackInB = s_q.ackInA;
    s_d.dinA = idDataIn;
    s_d.dinB = s_q.dinA;
    s_d.m8A = modulo8;
    s_d.m8B = s_q.m8A;
    s_d.lvlA = iackLevel;
    s_d.lvlB = s_q.lvlA;
    s_d.laA = laBase;
    s_d.laB = s_q.laA;

    // Level fan-in; channels with level zero never request
    s_d.irq = 7'h00;
    anyInh = 1'b0;
    hit = 1'b0;
    hitIdx = 3'h0;
    for (int i = NMOD - 1; i >= 0; i--)
    begin
      if (chReq[i] && s_q.ctl[i][LVL_LSB +: 3] != 3'h0)
        s_d.irq[3'(s_q.ctl[i][LVL_LSB +: 3] - 3'h1)] = 1'b1;
      anyInh = anyInh | s_q.ctl[i][INH_BIT];
      // Lowest slot wins when two share a level
      if (chReq[i] && s_q.ctl[i][LVL_LSB +: 3] == s_q.lvlB)
      begin
        hit = 1'b1;
        hitIdx = 3'(i);
      end
    end

    // Self-test outcome; inhibit on any slot masks the whole carrier
    s_d.lamp = testFail;
    s_d.sf = testFail && !anyInh;

    // ************************************************
    // Acknowledge cycle
    // ************************************************
    s_d.grant = 6'h00;
    unique case (s_q.ast)
      A_IDLE:
      begin
        s_d.aOut = s_q.iackB && s_q.ackInB;
        s_d.sidV = 1'b0;
        if (s_q.iackB && s_q.ackInB && hit)
        begin
          s_d.aOut = 1'b0;
          s_d.sel = hitIdx;
          s_d.mAck = 6'h01 << hitIdx;
          s_d.ast = A_WAIT;
        end
      end
      A_WAIT:
      begin
        if (!s_q.iackB)
        begin
          s_d.mAck = 6'h00;
          s_d.ast = A_IDLE;
        end
        else if (s_q.ctl[s_q.sel][IGN_BIT] || s_q.doneB[s_q.sel])
        begin
          s_d.mAck = 6'h00;
          s_d.grant = 6'h01 << s_q.sel;
          s_d.sid[7:0] = laOf(s_q.laB, s_q.m8B, int'(s_q.sel));
          s_d.sid[15:8] = s_q.ctl[s_q.sel][VSS_BIT] ? s_q.vecB[s_q.sel]
                                                    : s_q.ctl[s_q.sel][VEC_LSB +: 8];
          s_d.sidV = 1'b1;
          s_d.ast = A_HOLD;
        end
      end
      A_HOLD:
      begin
        if (!s_q.iackB)
        begin
          s_d.sidV = 1'b0;
          s_d.ast = A_IDLE;
        end
      end
      default: s_d.ast = A_IDLE;
    endcase

    // ************************************************
    // APB slave
    // ************************************************
    // Ready one cycle after setup keeps every output registered
    wrEn = psel && penable && s_q.rdy && pwrite;
    s_d.rdy = psel && !penable;
    s_d.err = 1'b0;
    if (psel && !penable)
    begin
      s_d.rd = 32'h00000000;
      s_d.err = 1'b1;
      for (int i = 0; i < NMOD; i++)
        if (paddr == 8'(CTL_BASE + 8'(i) * CTL_STRIDE))
        begin
          s_d.rd = {16'h0000, s_q.ctl[i]};
          s_d.err = 1'b0;
        end
      if (paddr == STAT_OFS)
      begin
        s_d.rd = {16'h0000, s_q.sf, testFail, extFound, scanDone, chHold, chReq};
        s_d.err = 1'b0;
      end
      if (paddr == MFR_OFS)
      begin
        s_d.rd = {16'h0000, mfrId};
        s_d.err = 1'b0;
      end
      if (paddr == DTYPE_OFS)
      begin
        // Memory exponent beside the raw word saves a software subtract
        s_d.rd = {11'h000, 5'(REQMEM_EXP - {1'b0, devType[REQMEM_LSB +: 4]}),
                  devType[REQMEM_LSB +: 4], devType[MODEL_LSB +: 12]};
        s_d.err = 1'b0;
      end
    end
    if (wrEn)
      for (int i = 0; i < NMOD; i++)
        if (paddr == 8'(CTL_BASE + 8'(i) * CTL_STRIDE)) s_d.ctl[i] = pwdata[15:0];
  end

  always_ff @(posedge clk or posedge rst)
    if (rst) s_q <= '{ctl: {NMOD{CTL_RESET}}, ast: A_IDLE, default: '0};
    else s_q <= s_d;

  // ************************************************
  // Outputs
  // ************************************************
  assign prdata = s_q.rd;
  assign pready = s_q.rdy;
  assign pslverr = s_q.err;
  assign irqOut = s_q.irq;
  assign ackOut = s_q.aOut;
  assign statusId = s_q.sid;
  assign statusIdValid = s_q.sidV;
  assign modAck = s_q.mAck;
  assign sysfail = s_q.sf;
  assign failLamp = s_q.lamp;

  // ************************************************
  // Checks
  // ************************************************
  a_zero_level_mute: assert property (@(posedge clk) disable iff (rst)
    s_q.ctl[0][LVL_LSB +: 3] == 3'h0 |=> !chReq[0]) else $error("level zero requested");
  a_level_drive: assert property (@(posedge clk) disable iff (rst)
    chReq[0] |=> irqOut[3'($past(s_q.ctl[0][LVL_LSB +: 3]) - 3'h1)]) else $error("level missing");
  a_vector_prog: assert property (@(posedge clk) disable iff (rst)
    $rose(statusIdValid) && !s_q.ctl[s_q.sel][VSS_BIT] |-> statusId[15:8] == s_q.ctl[s_q.sel][VEC_LSB +: 8])
    else $error("wrong programmed vector");
  a_vector_module: assert property (@(posedge clk) disable iff (rst)
    $rose(statusIdValid) && s_q.ctl[s_q.sel][VSS_BIT] |-> statusId[15:8] == $past(s_q.vecB[s_q.sel]))
    else $error("wrong module vector");
  a_addr_lower: assert property (@(posedge clk) disable iff (rst)
    $rose(statusIdValid) |-> statusId[7:0] == laOf(s_q.laB, s_q.m8B, int'(s_q.sel))) else $error("wrong address");
  a_ignore_resp: assert property (@(posedge clk) disable iff (rst)
    s_q.ast == A_WAIT && s_q.iackB && s_q.ctl[s_q.sel][IGN_BIT] |=> statusIdValid ##1 statusIdValid || !s_q.iackB)
    else $error("response not ignored");
  a_daisy_pass: assert property (@(posedge clk) disable iff (rst)
    s_q.ast == A_IDLE && !hit |=> ackOut == $past(s_q.iackB && s_q.ackInB)) else $error("chain not passed");
  a_inhibit_all: assert property (@(posedge clk) disable iff (rst)
    anyInh |=> !sysfail) else $error("inhibit ignored");
  a_fail_lamp: assert property (@(posedge clk) disable iff (rst)
    testFail && !anyInh |=> sysfail && failLamp) else $error("failure not shown");

  c_ack_served: cover property (@(posedge clk) disable iff (rst) $rose(statusIdValid));
  c_chain_pass: cover property (@(posedge clk) disable iff (rst) s_q.ast == A_IDLE && ackOut);
  c_ext_found: cover property (@(posedge clk) disable iff (rst) $rose(extFound));
endmodule : mezzanine_interrupt_ident_bridge

// >>> sim/mezz_modules.sv
`timescale 1ns/100ps
module mezz_modules
  import mezz_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Bench controls
  input wire logic [5:0] raise,
  input wire logic [5:0] clear,
  input wire logic [5:0] mute,
  input wire logic [5:0] ownVec,
  input wire logic [5:0] holdAck,
  // Carrier side
  input wire logic [5:0] modAck,
  output logic [5:0] modIrq,
  output logic [5:0][7:0] modVector,
  output logic [5:0] modAckDone,
  input wire logic [5:0] idSel,
  input wire logic idClk,
  input wire logic idDout,
  output logic idDataIn
);
  logic [7:0] tick;
  logic [5:0] selQ = 6'h00;
  logic [5:0] addr = 6'h00;
  logic [15:0] word = 16'h0000;
  logic bitQ = 1'b0;
  int bitCnt = 0;
  // ********************
  // Interrupters
  // ********************
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      modIrq <= 6'h00;
      tick <= 8'h00;
    end
    else
    begin
      tick <= tick + 8'h01;
      modIrq <= (modIrq & ~clear & ~(modAck & ~holdAck)) | raise;
    end
  // Silent modules never answer
  assign modAckDone = modAck & ~mute;
  // Undriven vector bus keeps changing so a stale byte cannot pass
  always_comb
    for (int s = 0; s < 6; s++)
      modVector[s] = (modAck[s] & ownVec[s]) ? 8'h3c + 8'(s) : tick ^ 8'(s);
  // ********************
  // Ident storage
  // ********************
  function automatic logic [15:0] rom(input logic [5:0] sel, input logic [5:0] a);
    if (sel[1])
      return 16'h0000;
    case (a)
      W_SYNC: return SYNC_BASE;
      W_SYNCX: return sel[0] ? SYNC_EXT : 16'h0000;
      W_MFR: return 16'h1234;
      W_DTYPE: return 16'h3abc;
      default: return 16'hffff;
    endcase
  endfunction : rom
  always @(posedge idClk)
  begin
    if (idSel != selQ)
      bitCnt = 0;
    selQ = idSel;
    if (bitCnt < 6)
      addr = {addr[4:0], idDout};
    if (bitCnt == 5)
      word = rom(idSel, addr);
    if (bitCnt >= 6)
      bitQ = word[21 - bitCnt];
    bitCnt = (bitCnt + 1) % 22;
  end
  assign idDataIn = (idSel != 6'h00) ? bitQ : ~bitQ;
endmodule : mezz_modules

// >>> sim/mezzanine_interrupt_ident_bridge_bench.sv
`timescale 1ns/100ps
module mezzanine_interrupt_ident_bridge_bench
  import mezz_pkg::*;
;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic iackActive = 1'b0;
  logic [2:0] iackLevel = 3'h0;
  logic ackIn = 1'b0;
  logic [5:0] modEnable = 6'h03;
  logic [7:0] laBase = 8'h50;
  logic modulo8 = 1'b0;
  logic [5:0] raise = 6'h00;
  logic [5:0] clear = 6'h00;
  logic [5:0] mute = 6'h00;
  logic [5:0] ownVec = 6'h00;
  logic [5:0] holdAck = 6'h00;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [6:0] irqOut;
  logic ackOut;
  logic [15:0] statusId;
  logic statusIdValid;
  logic [5:0] modIrq;
  logic [5:0][7:0] modVector;
  logic [5:0] modAckDone;
  logic [5:0] modAck;
  logic [5:0] idSel;
  logic idClk;
  logic idDout;
  logic idDataIn;
  logic sysfail;
  logic failLamp;
  logic [31:0] rd;
  logic er;
  int error_cnt = 0;
  int comparisons = 0;
  int i;
  always #2 clk = ~clk;
  mezzanine_interrupt_ident_bridge uut (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .irqOut, .iackActive, .iackLevel, .ackIn, .ackOut, .statusId, .statusIdValid, .modIrq, .modVector,
    .modAckDone, .modAck, .modEnable, .laBase, .modulo8, .idDataIn, .idSel, .idClk, .idDout, .sysfail, .failLamp);
  mezz_modules partner (.clk, .rst, .raise, .clear, .mute, .ownVec, .holdAck, .modAck, .modIrq, .modVector,
    .modAckDone, .idSel, .idClk, .idDout, .idDataIn);
  // ********************
  // Tasks
  // ********************
  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task end_of_test;
    $display("Comparisons %0d, errors %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : end_of_test
  task timeout;
    error_cnt++;
    $display("CHECK FAILED at %0t: wait ran out", $time);
    end_of_test();
  endtask : timeout
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
    begin
      n++;
      if (n > 50)
        timeout();
      @(posedge clk);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb
  task rdchk(input logic [7:0] a, input logic [31:0] exp, input logic expErr);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
    chk({31'h0, er}, {31'h0, expErr});
  endtask : rdchk
  // Polls a design output under a bound
  task waitFor(input int what, input logic [6:0] val);
    int n;
    logic seen;
    n = 0;
    seen = 1'b0;
    while (!seen)
    begin
      @(posedge clk);
      case (what)
        0: seen = (irqOut === val);
        1: seen = (statusIdValid === val[0]);
        2: seen = (ackOut === val[0]);
        default: seen = (sysfail === val[0]);
      endcase
      n++;
      if (n > 200)
        timeout();
    end
  endtask : waitFor
  task hit(input logic [5:0] r, input logic [5:0] c);
    raise <= r;
    clear <= c;
    @(posedge clk);
    raise <= 6'h00;
    clear <= 6'h00;
    repeat (8) @(posedge clk);
  endtask : hit
  task iack(input logic [2:0] lvl, input logic [15:0] exp);
    iackLevel <= lvl;
    iackActive <= 1'b1;
    ackIn <= 1'b1;
    waitFor(1, 7'h01);
    chk({16'h0, statusId}, {16'h0, exp});
    iackActive <= 1'b0;
    ackIn <= 1'b0;
    waitFor(1, 7'h00);
  endtask : iack
  // ********************
  // Sequence
  // ********************
  initial
  begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    for (i = 0; i < NMOD; i++)
      rdchk(8'(CTL_BASE + CTL_STRIDE * i), {16'h0, CTL_RESET}, 1'b0);
    rdchk(8'hfc, 32'h0, 1'b1);
    apb(1'b1, 8'h20, 32'hffffff7f);
    rdchk(8'h20, 32'h0000ff7f, 1'b0);
    apb(1'b1, 8'h20, 32'h0);
    // Pending request held back by level zero
    hit(6'h01, 6'h00);
    repeat (20) @(posedge clk);
    chk({25'h0, irqOut}, 32'h0);
    apb(1'b1, 8'h08, 32'h0000a503);
    waitFor(0, 7'h04);
    iack(3'h3, 16'ha550);
    waitFor(0, 7'h00);
    // Unclaimed acknowledge
    iackLevel <= 3'h6;
    iackActive <= 1'b1;
    ackIn <= 1'b1;
    waitFor(2, 7'h01);
    chk({31'h0, statusIdValid}, 32'h0);
    iackActive <= 1'b0;
    ackIn <= 1'b0;
    waitFor(2, 7'h00);
    // Module supplies its own vector
    modulo8 <= 1'b1;
    laBase <= 8'h40;
    ownVec <= 6'h02;
    apb(1'b1, 8'h20, 32'h00000025);
    hit(6'h02, 6'h00);
    waitFor(0, 7'h10);
    iack(3'h5, 16'h3d48);
    waitFor(0, 7'h00);
    // Register-access module with forced release
    holdAck <= 6'h01;
    apb(1'b1, 8'h08, 32'h0000000a);
    hit(6'h01, 6'h00);
    waitFor(0, 7'h02);
    iack(3'h2, 16'h0040);
    waitFor(0, 7'h00);
    repeat (20) @(posedge clk);
    chk({25'h0, irqOut}, 32'h0);
    rdchk(STAT_OFS, 32'h00000040, 1'b0);
    hit(6'h00, 6'h01);
    hit(6'h01, 6'h00);
    waitFor(0, 7'h02);
    iack(3'h2, 16'h0040);
    hit(6'h00, 6'h01);
    // Silent module, response ignored; its vector byte is not used
    mute <= 6'h02;
    apb(1'b1, 8'h20, 32'h00007714);
    hit(6'h02, 6'h00);
    waitFor(0, 7'h08);
    iack(3'h4, 16'h7748);
    // Power-up identification and self-test
    i = 0;
    rd = 32'h0;
    while (rd[12] !== 1'b1)
    begin
      repeat (20) @(posedge clk);
      apb(1'b0, STAT_OFS, 32'h0);
      i++;
      if (i > 3000)
        timeout();
    end
    chk({28'h0, rd[15:12]}, 32'hf);
    rdchk(MFR_OFS, 32'h00001234, 1'b0);
    rdchk(DTYPE_OFS, 32'h00143abc, 1'b0);
    chk({30'h0, sysfail, failLamp}, 32'h3);
    apb(1'b1, 8'h08, 32'h00000040);
    waitFor(3, 7'h00);
    end_of_test();
  end
endmodule : mezzanine_interrupt_ident_bridge_bench
